// *** ehci_pci_config_extension_tb.sv ***
`timescale 1ns/1ps

module ehci_pci_config_extension_tb;
   import ehcx_pkg::*;

   logic        clk;
   logic        reset_n;
   logic [7:0]  cfg_addr;
   logic        cfg_read;
   logic        cfg_write;
   logic [3:0]  cfg_byte_en;
   logic [31:0] cfg_wdata;
   logic [31:0] cfg_rdata;
   logic        cfg_rvalid;
   logic        microframe_start;
   logic [15:0] microframe_length;
   int          miscompares;
   int          samples_checked;
   int          cyc;
   int          trim_m;
   int          wake_m;
   logic [31:0] rnd;
   logic [7:0]  unmapped [6] = '{8'h00, 8'h40, 8'h64, 8'hd8, 8'he0, 8'hfc};
   logic [7:0]  ro_addr [4] = '{8'h34, 8'h60, 8'hdc, 8'hdd};

   ehcx_config_ext ehcx_config_ext_i (
      .clk               (clk),
      .reset_n           (reset_n),
      .cfg_addr          (cfg_addr),
      .cfg_read          (cfg_read),
      .cfg_write         (cfg_write),
      .cfg_byte_en       (cfg_byte_en),
      .cfg_wdata         (cfg_wdata),
      .cfg_rdata         (cfg_rdata),
      .cfg_rvalid        (cfg_rvalid),
      .microframe_start  (microframe_start),
      .microframe_length (microframe_length)
   );

   // Free-running 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Edges seen since reset release, for frame timing
   always @(posedge clk) begin
      if (reset_n) cyc++;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Bench image of dword 60h, from the register layout
   function automatic logic [31:0] usb_word();
      return {wake_m[15:0], 2'b00, trim_m[5:0], 8'h20};
   endfunction

   // Read: one-cycle pulse, answer exactly one cycle later
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      cfg_read <= 1'b1;
      cfg_addr <= a;
      @(posedge clk);
      cfg_read <= 1'b0;
      #1;
      check("rvalid", 32'h1, {31'h0, cfg_rvalid});
      check("rdata", exp, cfg_rdata);
   endtask

   // Write: model follows only the writable lanes of dword 60h
   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(posedge clk);
      cfg_write   <= 1'b1;
      cfg_addr    <= a;
      cfg_byte_en <= be;
      cfg_wdata   <= d;
      @(posedge clk);
      cfg_write <= 1'b0;
      if (a[7:2] == 6'h18) begin
         if (be[1]) trim_m = d[13:8];
         if (be[2]) wake_m[7:0] = d[23:16];
         if (be[3]) wake_m[15:8] = d[31:24];
      end
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Watchdog sized a little past the first microframe
   initial begin
      repeat (62000) @(posedge clk);
      miscompares++;
      complete_run();
   end

   initial begin
      reset_n     = 1'b0;
      cfg_addr    = 8'h00;
      cfg_read    = 1'b0;
      cfg_write   = 1'b0;
      cfg_byte_en = 4'h0;
      cfg_wdata   = 32'h0;
      trim_m      = 32;
      wake_m      = 32'h001f;
      cyc         = 0;
      rnd         = $urandom(32'hdced);
      repeat (8) @(posedge clk);
      #1;
      check("rvalid_rst", 32'h0, {31'h0, cfg_rvalid});
      check("len_rst", 32'hea60, {16'h0, microframe_length});
      reset_n <= 1'b1;
      // Reset image seen through every byte address of each word
      for (int i = 0; i < 4; i++) begin
         rd(8'h60 + i[7:0], 32'h001f2020);
         rd(8'h34 + i[7:0], 32'h000000dc);
         rd(8'hdc + i[7:0], 32'h00000001);
      end
      // Random lane writes, read-only targets and unmapped holes
      for (int i = 0; i < 24; i++) begin
         rnd = $urandom();
         wr({6'h18, rnd[1:0]}, rnd[5:2], $urandom());
         wr(ro_addr[i % 4], 4'h1, $urandom());
         wr(unmapped[i % 6], 4'hf, $urandom());
         rd(8'h60, usb_word());
         rd(unmapped[i % 6], 32'h0);
      end
      rd(8'h34, 32'h000000dc);
      rd(8'hdc, 32'h00000001);
      // Boundary trims last, so the next frame length is an extreme value
      wr(8'h61, 4'h2, 32'h0000ff00);
      rd(8'h61, usb_word());
      check("len_mid", 32'hea60, {16'h0, microframe_length});
      // Frame started at reset must still run its full default length
      do begin
         @(posedge clk);
         #1;
      end while (microframe_start !== 1'b1 && cyc < 61000);
      check("first_start", 32'h1, {31'h0, microframe_start});
      check("frame_span", 32'h1, {31'h0, (cyc >= 59999 && cyc <= 60001)});
      check("len_new", 59488 + 16 * trim_m, {16'h0, microframe_length});
      // Boundary strobe stands a single cycle, length holds after it
      @(posedge clk);
      #1;
      check("start_pulse", 32'h0, {31'h0, microframe_start});
      check("len_hold", 59488 + 16 * trim_m, {16'h0, microframe_length});
      complete_run();
   end

endmodule

// *** ehcx_config_ext.sv ***
`timescale 1ns/1ps

module ehcx_config_ext
   import ehcx_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic        cfg_read,
   input  wire logic        cfg_write,
   input  wire logic [3:0]  cfg_byte_en,
   input  wire logic [31:0] cfg_wdata,
   output      logic [31:0] cfg_rdata,
   output      logic        cfg_rvalid,
   output      logic        microframe_start,
   output      logic [15:0] microframe_length
);

   typedef struct packed {
      logic [EHCX_TRIM_W-1:0] trim;
      logic [15:0]            wake_mask;
      logic [31:0]            rdata;
      logic                   rvalid;
   } ehcx_cfg_state_t;

   ehcx_cfg_state_t cfg_reg;
   ehcx_cfg_state_t cfg_next;

   logic [EHCX_DW_W-1:0] dword;
   logic                 hit_usb;
   logic                 hit_cap_ptr;
   logic                 hit_pm;
   logic [31:0]          usb_word;
   logic [31:0]          pm_word;
   logic [31:0]          cap_ptr_word;

   // Dword decode; byte lanes pick the bytes inside the word
   assign dword       = cfg_addr[EHCX_DW_LSB +: EHCX_DW_W];
   assign hit_usb     = (dword == EHCX_DW_USB);
   assign hit_cap_ptr = (dword == EHCX_DW_CAP_PTR);
   assign hit_pm      = (dword == EHCX_DW_PM);

   // Word at 60h: release, trim with zero top bits, wake mask
   always_comb begin
      usb_word = '0;
      usb_word[EHCX_LANE0_LSB +: EHCX_BYTE_W] = EHCX_RELEASE_VAL;
      usb_word[EHCX_LANE1_LSB +: EHCX_TRIM_FIELD_W] =
         EHCX_TRIM_FIELD_W'(cfg_reg.trim);
      usb_word[EHCX_LANE2_LSB +: 16] = cfg_reg.wake_mask;
   end

   // Pointer word: only the low byte is ours, the rest of the header is elsewhere
   always_comb begin
      cap_ptr_word = '0;
      cap_ptr_word[EHCX_LANE0_LSB +: EHCX_BYTE_W] = EHCX_CAP_PTR_VAL;
   end

   // Power management head: identifier then end-of-list pointer
   always_comb begin
      pm_word = '0;
      pm_word[EHCX_LANE0_LSB +: EHCX_BYTE_W] = EHCX_CAPABILITY_IDENTIFIER_VAL;
      pm_word[EHCX_LANE1_LSB +: EHCX_BYTE_W] = EHCX_NEXT_VAL;
   end

   // Read returns the whole word; unmapped words read zero
   always_comb begin
      cfg_next        = cfg_reg;
      cfg_next.rvalid = cfg_read;
      if (cfg_read) begin
         if (hit_usb) begin
            cfg_next.rdata = usb_word;
         end else if (hit_cap_ptr) begin
            cfg_next.rdata = cap_ptr_word;
         end else if (hit_pm) begin
            cfg_next.rdata = pm_word;
         end else begin
            cfg_next.rdata = '0;
         end
      end
      // Writes to read-only bytes and to unmapped words are dropped
      if (cfg_write && hit_usb) begin
         if (cfg_byte_en[1]) begin
            cfg_next.trim = cfg_wdata[EHCX_LANE1_LSB +: EHCX_TRIM_W];
         end
         if (cfg_byte_en[2]) begin
            cfg_next.wake_mask[7:0] = cfg_wdata[EHCX_LANE2_LSB +: EHCX_BYTE_W];
         end
         if (cfg_byte_en[3]) begin
            cfg_next.wake_mask[15:8] = cfg_wdata[EHCX_LANE3_LSB +: EHCX_BYTE_W];
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_reg.trim      <= EHCX_TRIM_RST;
         cfg_reg.wake_mask <= EHCX_WAKE_RST;
         cfg_reg.rdata     <= '0;
         cfg_reg.rvalid    <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
      end
   end

   assign cfg_rdata  = cfg_reg.rdata;
   assign cfg_rvalid = cfg_reg.rvalid;

   // Only trim reaches the counter; the wake mask stays a plain store
   ehcx_frame_counter u_frame_counter (
      .clk               (clk),
      .reset_n           (reset_n),
      .trim              (cfg_reg.trim),
      .microframe_start  (microframe_start),
      .microframe_length (microframe_length)
   );

   a_release_fixed: assert property (
      @(posedge clk) disable iff (!reset_n)
      (cfg_read && hit_usb) |=> cfg_rvalid &&
         cfg_rdata[EHCX_LANE0_LSB +: EHCX_BYTE_W] == EHCX_RELEASE_VAL)
      else $error("release number byte is not 20h");

   a_trim_top_zero: assert property (
      @(posedge clk) disable iff (!reset_n)
      (cfg_read && hit_usb) |=> cfg_rdata[EHCX_LANE1_LSB + EHCX_TRIM_W +: 2] == 2'h0)
      else $error("reserved trim bits read nonzero");

   a_trim_write: assert property (
      @(posedge clk) disable iff (!reset_n)
      (cfg_write && hit_usb && cfg_byte_en[1]) |=> cfg_reg.trim ==
         $past(cfg_wdata[EHCX_LANE1_LSB +: EHCX_TRIM_W]))
      else $error("trim write not stored");

   a_trim_hold: assert property (
      @(posedge clk) disable iff (!reset_n)
      !(cfg_write && hit_usb && cfg_byte_en[1]) |=> $stable(cfg_reg.trim))
      else $error("trim changed without a write");

   a_wake_write: assert property (
      @(posedge clk) disable iff (!reset_n)
      (cfg_write && hit_usb && cfg_byte_en[3]) |=> cfg_reg.wake_mask[15:8] ==
         $past(cfg_wdata[EHCX_LANE3_LSB +: EHCX_BYTE_W]))
      else $error("wake mask high byte not stored");

   a_wake_readback: assert property (
      @(posedge clk) disable iff (!reset_n)
      (cfg_read && hit_usb) |=> cfg_rdata[EHCX_LANE2_LSB +: 16] == $past(cfg_reg.wake_mask))
      else $error("wake mask read mismatch");

   a_cap_pointer: assert property (
      @(posedge clk) disable iff (!reset_n)
      (cfg_read && hit_cap_ptr) |=> cfg_rdata == 32'(EHCX_CAP_PTR_VAL))
      else $error("capabilities pointer is not DCh");

   a_cap_head: assert property (
      @(posedge clk) disable iff (!reset_n)
      (cfg_read && hit_pm) |=> cfg_rdata[EHCX_LANE0_LSB +: EHCX_BYTE_W] == EHCX_CAPABILITY_IDENTIFIER_VAL
         && cfg_rdata[EHCX_LANE1_LSB +: EHCX_BYTE_W] == EHCX_NEXT_VAL)
      else $error("capability head bytes wrong");

   a_unmapped_zero: assert property (
      @(posedge clk) disable iff (!reset_n)
      (cfg_read && !hit_usb && !hit_cap_ptr && !hit_pm) |=> cfg_rdata == 32'h0000_0000)
      else $error("unmapped word read nonzero");

   a_rvalid_pulse: assert property (
      @(posedge clk) disable iff (!reset_n)
      cfg_read |=> cfg_rvalid ##1 (cfg_rvalid == $past(cfg_read)))
      else $error("read strobe not answered next cycle");

   a_trim_default: assert property (
      @(posedge clk)
      $rose(reset_n) |-> cfg_reg.trim == EHCX_TRIM_RST && cfg_reg.wake_mask == EHCX_WAKE_RST)
      else $error("reset values wrong");

endmodule

// *** ehcx_frame_counter.sv ***
`timescale 1ns/1ps

module ehcx_frame_counter
   import ehcx_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire logic [EHCX_TRIM_W-1:0] trim,
   output      logic                  microframe_start,
   output      logic [EHCX_LEN_W-1:0] microframe_length
);

   typedef struct packed {
      logic [EHCX_LEN_W-1:0] count;
      logic [EHCX_LEN_W-1:0] length;
      logic                  start;
   } ehcx_fc_state_t;

   ehcx_fc_state_t fc_reg;
   ehcx_fc_state_t fc_next;
   logic [EHCX_LEN_W-1:0] new_length;
   logic                  last_period;

   // Length from trim: base plus sixteen bit times per step
   assign new_length  = EHCX_FRAME_BASE + EHCX_LEN_W'(trim) * EHCX_TRIM_STEP;
   assign last_period = (fc_reg.count == fc_reg.length - EHCX_LEN_W'(1));

   // Length reloads only at a boundary so a running frame keeps its size
   always_comb begin
      fc_next       = fc_reg;
      fc_next.start = 1'b0;
      if (last_period) begin
         fc_next.count  = '0;
         fc_next.length = new_length;
         fc_next.start  = 1'b1;
      end else begin
         fc_next.count = fc_reg.count + EHCX_LEN_W'(1);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fc_reg.count  <= '0;
         fc_reg.length <= EHCX_FRAME_RST;
         fc_reg.start  <= 1'b0;
      end else begin
         fc_reg <= fc_next;
      end
   end

   assign microframe_start  = fc_reg.start;
   assign microframe_length = fc_reg.length;

   // Helper: cycles since last start, and whether one was seen
   logic [EHCX_LEN_W-1:0] gap_reg;
   logic                  seen_reg;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         gap_reg  <= '0;
         seen_reg <= 1'b0;
      end else begin
         gap_reg  <= fc_reg.start ? EHCX_LEN_W'(1) : gap_reg + EHCX_LEN_W'(1);
         seen_reg <= seen_reg | fc_reg.start;
      end
   end

   a_period_matches: assert property (
      @(posedge clk) disable iff (!reset_n)
      (microframe_start && seen_reg) |-> gap_reg == $past(microframe_length))
      else $error("microframe period differs from programmed length");

   a_length_loaded: assert property (
      @(posedge clk) disable iff (!reset_n)
      microframe_start |-> microframe_length ==
         $past(EHCX_FRAME_BASE + EHCX_LEN_W'(trim) * EHCX_TRIM_STEP))
      else $error("loaded length does not follow trim");

   a_length_steady: assert property (
      @(posedge clk) disable iff (!reset_n)
      !last_period |=> $stable(microframe_length))
      else $error("length changed inside a microframe");

   a_length_range: assert property (
      @(posedge clk) disable iff (!reset_n)
      microframe_length >= EHCX_FRAME_BASE && microframe_length <= EHCX_FRAME_MAX)
      else $error("microframe length out of range");

endmodule

// *** ehcx_pkg.sv ***
package ehcx_pkg;

   // Configuration offsets, byte addresses
   localparam logic [7:0]  EHCX_OFF_CAP_PTR   = 8'h34;
   localparam logic [7:0]  EHCX_OFF_RELEASE   = 8'h60;
   localparam logic [7:0]  EHCX_OFF_TRIM      = 8'h61;
   localparam logic [7:0]  EHCX_OFF_WAKE      = 8'h62;
   localparam logic [7:0]  EHCX_OFF_PM_BASE   = 8'hdc;

   // Offsets inside the power management structure
   localparam logic [7:0]  EHCX_PM_REL_CAPABILITY_IDENTIFIER = 8'h00;
   localparam logic [7:0]  EHCX_PM_REL_NEXT   = 8'h01;
   localparam logic [7:0]  EHCX_PM_REL_PWRCAP = 8'h02;
   localparam logic [7:0]  EHCX_PM_REL_CTLSTS = 8'h04;
   localparam logic [7:0]  EHCX_PM_REL_BRIDGE = 8'h06;
   localparam logic [7:0]  EHCX_PM_REL_DATA   = 8'h07;

   // Dword index width and byte-in-dword width
   localparam int          EHCX_DW_LSB        = 2;
   localparam int          EHCX_DW_W          = 6;

   // Byte lane positions inside a dword
   localparam int          EHCX_LANE0_LSB     = 0;
   localparam int          EHCX_LANE1_LSB     = 8;
   localparam int          EHCX_LANE2_LSB     = 16;
   localparam int          EHCX_LANE3_LSB     = 24;
   localparam int          EHCX_BYTE_W        = 8;

   // Frame length trim field
   localparam int          EHCX_TRIM_W        = 6;
   localparam int          EHCX_TRIM_FIELD_W  = 8;

   // Fixed and reset values
   localparam logic [7:0]  EHCX_RELEASE_VAL   = 8'h20;
   localparam logic [5:0]  EHCX_TRIM_RST      = 6'h20;
   localparam logic [15:0] EHCX_WAKE_RST      = 16'h001f;
   localparam logic [7:0]  EHCX_CAP_PTR_VAL   = 8'hdc;
   localparam logic [7:0]  EHCX_CAPABILITY_IDENTIFIER_VAL    = 8'h01;
   localparam logic [7:0]  EHCX_NEXT_VAL      = 8'h00;

   // Microframe length in counter clock periods
   localparam int          EHCX_LEN_W         = 16;
   localparam logic [15:0] EHCX_FRAME_BASE    = 16'he860;
   localparam logic [15:0] EHCX_TRIM_STEP     = 16'h0010;
   localparam logic [15:0] EHCX_FRAME_MAX     = 16'hec50;
   localparam logic [15:0] EHCX_FRAME_RST     = 16'hea60;

   // Dword indices of the mapped words
   localparam logic [5:0]  EHCX_DW_CAP_PTR    = EHCX_OFF_CAP_PTR[7:2];
   localparam logic [5:0]  EHCX_DW_USB        = EHCX_OFF_RELEASE[7:2];
   localparam logic [5:0]  EHCX_DW_PM         = EHCX_OFF_PM_BASE[7:2];

endpackage
